/* verilog/ttl_consts.svh */
// constants for the overheat trip latch
// Operation
// - comparator over trip level halts execution and asserts active-low trip output.
// - trip output and halt stay latched until system reset goes active.
// - no hysteresis; reset with comparator below trip clears latch, execution resumes.
// - comparator still over trip after reset re-asserts trip and halt; halt here drops in reset and returns three enabled edges after release.
// - trip output value is undefined while system reset is asserted.
`ifndef TTL_CONSTS_SVH
`define TTL_CONSTS_SVH
`define TTL_SYNC_STAGES 2
`define TTL_TRIP_LEVEL_DEGC 135
`define TTL_STATE_RUN  2'h1
`define TTL_STATE_TRIP 2'h2
`endif

/* verilog/ttl_pkg.sv */
// types for the overheat trip latch
`default_nettype none
`include "ttl_consts.svh"
package ttl_pkg;
	typedef enum logic [1:0] {
		TTL_RUN  = `TTL_STATE_RUN,
		TTL_TRIP = `TTL_STATE_TRIP
	} ttl_state_e;
	typedef struct packed {
		logic halt;
		logic trip_n;
	} ttl_out_s;
endpackage : ttl_pkg
`default_nettype wire

/* verilog/ttl_thermal_trip_latch.sv */
// overheat trip latch: synchronised comparator, latched halt and trip output
`timescale 1ns/1ps
`default_nettype none
`include "ttl_consts.svh"
module ttl_thermal_trip_latch
	import ttl_pkg::*;
(
	// clock, reset, enable
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic clk_en,
	// comparator from the thermal sensor
	input  wire logic over_temp,
	// outputs to core and system
	output var  logic exec_halt,
	output var  logic overheat_trip_n
);
	// synchroniser stages, latch state and registered outputs
	logic [`TTL_SYNC_STAGES-1:0] sync_reg;
	logic [`TTL_SYNC_STAGES-1:0] sync_next;
	ttl_state_e                  state_reg;
	ttl_state_e                  state_next;
	ttl_out_s                    out_reg;
	ttl_out_s                    out_next;
	logic                        hot;

	// the latched state is tested in several places, so it is decoded once here
	function automatic logic is_tripped(input ttl_state_e st);
		return (st == TTL_TRIP);
	endfunction : is_tripped

	// first stage takes the raw comparator level
	// a level that changes close to the edge may leave this stage unsettled,
	// which is why nothing but the next stage ever reads it
	assign sync_next[0] = over_temp;

	// remaining stages shift the level on, one stage per enabled edge
	for (genvar i = 1; i < `TTL_SYNC_STAGES; i++) begin : g_sync
		assign sync_next[i] = sync_reg[i-1];
	end

	// only the last stage feeds the latch; it costs two edges of latency,
	// which is small against how slowly a die heats up
	assign hot = sync_reg[`TTL_SYNC_STAGES-1];

	// latch: only reset leaves trip, so a cooling die cannot release the halt
	// there is no hysteresis here: a cool comparator after reset simply
	// leaves the latch in run, and a hot one sets it again three enabled edges later, once through the synchroniser
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			TTL_RUN: begin
				if (hot) begin
					state_next = TTL_TRIP;
				end
			end
			TTL_TRIP: begin
				state_next = TTL_TRIP;
			end
			default: begin
				// an illegal code is treated as hot: stopping is the safe side
				state_next = TTL_TRIP;
			end
		endcase
		// both outputs come from the same decode so they cannot disagree
		out_next.halt   = is_tripped(state_next);
		out_next.trip_n = !is_tripped(state_next);
	end

	// reset clears the latch with no hysteresis; re-trip follows if still hot
	// clock enable low freezes every stage, synchroniser included
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_reg  <= '0;
			state_reg <= TTL_RUN;
			out_reg   <= '{halt: 1'b0, trip_n: 1'b1}; // defined though not promised
		end else if (clk_en) begin
			sync_reg  <= sync_next;
			state_reg <= state_next;
			out_reg   <= out_next;
		end
	end

	// outputs straight from flip-flops, so the system sees no glitches
	assign exec_halt       = out_reg.halt;
	assign overheat_trip_n = out_reg.trip_n;

	// a trip never lets go until reset
	a_trip_sticky: assert property (
		@(posedge clk) disable iff (!nrst)
		!overheat_trip_n |=> !overheat_trip_n)
		else $error("trip output released without reset");

	// a hot synchronised comparator trips on the next enabled edge
	a_trip_on_hot: assert property (
		@(posedge clk) disable iff (!nrst)
		(clk_en && hot && !$past(!nrst)) |=> !overheat_trip_n)
		else $error("trip not asserted after hot comparator");

	// halt and trip output are two views of one state
	a_halt_tracks: assert property (
		@(posedge clk) disable iff (!nrst)
		exec_halt == !overheat_trip_n)
		else $error("halt and trip output disagree");

	// comparator reaches the latch after two enabled edges
	a_sync_delay: assert property (
		@(posedge clk) disable iff (!nrst)
		(clk_en && over_temp) ##1 clk_en |=> hot)
		else $error("comparator not synchronised in two stages");

	// a cool comparator never trips a running core
	a_cool_runs: assert property (
		@(posedge clk) disable iff (!nrst)
		($rose(nrst) || (!hot && overheat_trip_n)) ##0 !hot |=> overheat_trip_n)
		else $error("trip asserted while comparator cool");

	// still hot after reset means tripped again
	a_retrip_hot: assert property (
		@(posedge clk) disable iff (!nrst)
		(hot && clk_en) [*2] |=> !overheat_trip_n)
		else $error("no re-trip while still hot");

	// clock enable low freezes the trip output
	a_freeze_en: assert property (
		@(posedge clk) disable iff (!nrst)
		!clk_en |=> $stable(overheat_trip_n))
		else $error("state moved while clock enable low");

	// halt is as sticky as the trip output
	a_halt_sticky: assert property (
		@(posedge clk) disable iff (!nrst)
		exec_halt |=> exec_halt)
		else $error("halt released without reset");

	// first stage copies the comparator on each enabled edge
	a_sync_first: assert property (
		@(posedge clk) disable iff (!nrst)
		clk_en |=> (sync_reg[0] == $past(over_temp)))
		else $error("first sync stage missed the comparator");

	// last stage copies the first stage on each enabled edge
	a_sync_last: assert property (
		@(posedge clk) disable iff (!nrst)
		clk_en |=> (hot == $past(sync_reg[0])))
		else $error("last sync stage missed the first");

	// a halt only ever starts from a hot comparator
	a_halt_cause: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(exec_halt) |-> $past(hot))
		else $error("halt raised without hot comparator");

	// the trip output follows the latch state
	a_out_state: assert property (
		@(posedge clk) disable iff (!nrst)
		!overheat_trip_n == is_tripped(state_reg))
		else $error("trip output does not match latch state");

	// a running core is never halted
	a_run_free: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_reg == TTL_RUN) |-> !exec_halt)
		else $error("halt high while latch in run");

	// the latch state itself does not move with clock enable low
	a_freeze_state: assert property (
		@(posedge clk) disable iff (!nrst)
		!clk_en |=> $stable(state_reg))
		else $error("latch state moved while clock enable low");

	// halt output is frozen too with clock enable low
	a_freeze_halt: assert property (
		@(posedge clk) disable iff (!nrst)
		!clk_en |=> $stable(exec_halt))
		else $error("halt moved while clock enable low");

	// a cool comparator on a running core keeps the core running
	a_cool_holds: assert property (
		@(posedge clk) disable iff (!nrst)
		(!hot && overheat_trip_n) |=> overheat_trip_n)
		else $error("trip appeared from a cool comparator");

	// the latch only ever holds one of its two legal codes
	a_state_legal: assert property (
		@(posedge clk) disable iff (!nrst)
		(state_reg == TTL_RUN) || (state_reg == TTL_TRIP))
		else $error("latch state holds an illegal code");

	// an enabled cool edge with an untripped latch keeps the halt low
	a_cool_no_halt: assert property (
		@(posedge clk) disable iff (!nrst)
		(clk_en && !hot && !exec_halt) |=> !exec_halt)
		else $error("halt appeared from a cool comparator");

	// a hot enabled edge raises the halt on the next edge
	a_halt_on_hot: assert property (
		@(posedge clk) disable iff (!nrst)
		(clk_en && hot) |=> exec_halt)
		else $error("halt not raised after hot comparator");

	// a pulse held for one enabled edge still reaches the last stage
	a_pulse_kept: assert property (
		@(posedge clk) disable iff (!nrst)
		(clk_en && over_temp) ##1 clk_en ##1 clk_en |=> exec_halt)
		else $error("captured comparator pulse lost");

	// limitation: while reset is low the outputs hold their reset values,
	// but the system must not rely on them then; none of the checks above
	// look inside reset for that reason
endmodule : ttl_thermal_trip_latch
`default_nettype wire

/* sim/ttl_monitor.sv */
// system-side watcher of the trip output
`timescale 1ns/1ps
`default_nettype none
module ttl_monitor (
	// clock, reset, trip input
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic overheat_trip_n,
	// pulse on each new trip
	output var  logic trip_seen
);
	logic was_reg;
	// trip is meaningless in reset, so acting waits for release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) was_reg <= 1'b0;
		else was_reg <= !overheat_trip_n;
	end
	assign trip_seen = nrst && !overheat_trip_n && !was_reg;
endmodule : ttl_monitor
`default_nettype wire

/* sim/thermal_trip_latch_test.sv */
// bench: trip latency, latching and reset behaviour
`timescale 1ns/1ps
`default_nettype none
module thermal_trip_latch_test;
	import ttl_pkg::*;
	logic clk = 0, nrst = 0, clk_en = 1, over_temp = 0, trip_seen;
	logic [7:0] lfsr = 8'h43;
	ttl_out_s o;
	int cyc, bad_count, total_checks, q[$];
	ttl_thermal_trip_latch i_dut (.clk(clk), .nrst(nrst), .clk_en(clk_en),
		.over_temp(over_temp), .exec_halt(o.halt), .overheat_trip_n(o.trip_n));
	ttl_monitor i_mon (.clk(clk), .nrst(nrst), .overheat_trip_n(o.trip_n),
		.trip_seen(trip_seen));
	always #2.5 clk = ~clk;
	function automatic logic [7:0] lfsr_step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_step
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %0h want %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d bad %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// each trip must land on the noted cycle
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (trip_seen) chk(cyc, q.size() ? q.pop_front() : -1);
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		lfsr = lfsr_step(lfsr);
		repeat (lfsr[2:0]) @(posedge clk);
		over_temp <= 1'b1;
		q.push_back(cyc + 4);
		repeat (lfsr[4:3] + 1) @(posedge clk);
		over_temp <= 1'b0;
		repeat (9) @(posedge clk);
		chk({o.halt, o.trip_n}, 2'b10);
		$display("latch test done");
		nrst <= 1'b0;
		@(posedge clk) nrst <= 1'b1;
		repeat (9) @(posedge clk);
		chk({o.halt, o.trip_n}, 2'b01);
		$display("cool reset test done");
		// clock enable low must freeze the synchroniser: no trip while frozen
		lfsr = lfsr_step(lfsr);
		clk_en <= 1'b0;
		over_temp <= 1'b1;
		repeat (lfsr[2:0] + 4) @(posedge clk);
		chk({o.halt, o.trip_n}, 2'b01);
		clk_en <= 1'b1;
		q.push_back(cyc + 4);
		repeat (6) @(posedge clk);
		nrst <= 1'b0;
		q.push_back(cyc + 5);
		@(posedge clk) nrst <= 1'b1;
		repeat (9) @(posedge clk);
		chk({o.halt, o.trip_n}, 2'b10);
		chk(q.size(), 0);
		$display("enable and re-trip tests done");
		test_done();
	end
endmodule : thermal_trip_latch_test
`default_nettype wire
